// *** dv/pg_host.sv ***
`timescale 1ns/10ps
module pg_host
  import pg_pkg::*;
(
  input wire logic core_clk_in,
  output logic sel_out,
  output logic wr_out,
  output logic iack_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out,
  input wire logic [15:0] rdata_in,
  input wire logic ack_in
);
  initial
  begin
    sel_out = 1'b0;
    wr_out = 1'b0;
    iack_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // one pulsed request, bounded wait for ack
  task automatic access(input logic w, input logic ia, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] x);
    int k;
    @(posedge core_clk_in);
    sel_out <= 1'b1;
    wr_out <= w;
    iack_out <= ia;
    addr_out <= a;
    wdata_out <= d;
    @(posedge core_clk_in);
    sel_out <= 1'b0;
    k = 0;
    @(posedge core_clk_in);
    while (ack_in !== 1'b1 && k < 8)
    begin
      @(posedge core_clk_in);
      k++;
    end
    x = rdata_in;
  endtask
endmodule

// *** dv/pg_regs_monitor.sv ***
`timescale 1ns/10ps
module pg_regs_monitor
  import pg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic bus_sel_in,
  input wire logic bus_wr_in,
  input wire logic bus_iack_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  input wire logic [15:0] bus_rdata_out,
  input wire logic bus_ack_out,
  input wire logic irq_n_out,
  input wire logic pat_ready_in,
  input wire logic pat_valid_out,
  input wire logic [15:0] chan_data_out,
  input wire logic sync_mark_out,
  input wire logic running_out
);
  logic wr_ok;
  logic ctl_wr;
  logic kind_ff;
  logic [7:0] vec_ff;
  assign wr_ok = bus_sel_in & bus_wr_in & !bus_iack_in;
  assign ctl_wr = wr_ok & (bus_addr_in == PG_OFS_CTRL);
  // shadow of irq kind and vector
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      kind_ff <= 1'b0;
      vec_ff <= 8'h00;
    end
    else if (wr_ok && bus_addr_in == PG_OFS_IRQ)
    begin
      kind_ff <= bus_wdata_in[14];
      vec_ff <= bus_wdata_in[7:0];
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_ack_next_cycle: assert property (bus_ack_out == $past(bus_sel_in))
    else $error("ack timing");
  a_vector_byte: assert property (bus_sel_in & bus_iack_in |=>
    bus_rdata_out == {8'h00, $past(vec_ff)})
    else $error("vector");
  a_kind_c_clear: assert property (bus_sel_in & bus_iack_in & kind_ff |-> ##3 irq_n_out)
    else $error("type c irq");
  a_master_off: assert property (wr_ok & bus_addr_in == PG_OFS_IRQ &
    !bus_wdata_in[15] |-> ##3 irq_n_out)
    else $error("irq without master");
  a_word_holds: assert property (pat_valid_out & !pat_ready_in |=>
    pat_valid_out && $stable(chan_data_out) && $stable(sync_mark_out))
    else $error("word not held");
  a_marker_valid: assert property (sync_mark_out |-> pat_valid_out)
    else $error("marker alone");
  a_reset_idles: assert property (ctl_wr & bus_wdata_in[7] |-> ##3 !running_out [*3])
    else $error("reset bit");
  a_run_bit_off: assert property (ctl_wr & !bus_wdata_in[0] |-> ##3 !running_out)
    else $error("run bit");
  c_iack: cover property (bus_sel_in & bus_iack_in);
  c_marker: cover property (sync_mark_out & pat_ready_in);
  c_stall: cover property (pat_valid_out & !pat_ready_in);
endmodule
bind pg_regs pg_regs_monitor u_mon (.*);

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench
  import pg_pkg::*;
;
  logic clk, rst_n, sel, wr_en, iack, ack, irq_n, fclk, fgo, ta, tb, rdy, vld, mark, run;
  logic hold, stall;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, cdata, coe;
  int fails, comparisons;
  pg_word_t q[$];
  pg_regs dut (.core_clk_in(clk), .rst_n_in(rst_n), .bus_sel_in(sel), .bus_wr_in(wr_en),
    .bus_iack_in(iack), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
    .bus_ack_out(ack), .irq_n_out(irq_n), .front_clock_in(fclk), .front_go_in(fgo),
    .trig_a_in(ta), .trig_b_in(tb), .pat_ready_in(rdy), .pat_valid_out(vld),
    .chan_data_out(cdata), .chan_oe_out(coe), .sync_mark_out(mark), .running_out(run));
  pg_host host (.core_clk_in(clk), .sel_out(sel), .wr_out(wr_en), .iack_out(iack),
    .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata), .ack_in(ack));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // receiver with optional stall
  always @(posedge clk)
  begin
    rdy <= hold ? 1'b0 : (stall ? ~rdy : 1'b1);
    if (rst_n && vld && rdy)
      q.push_back('{mark, coe, cdata});
  end
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    logic [15:0] x;
    host.access(1'b1, 1'b0, a, d, x);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    logic [15:0] x;
    host.access(1'b0, 1'b0, a, 16'h0000, x);
    chk(x, e);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic words(int n);
    int k;
    k = 0;
    while (q.size() < n && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
  endtask
  // selected line gets l, the others its inverse
  task automatic lines(logic [1:0] s, logic l);
    @(posedge clk);
    fgo <= (s == 2'h1) ? l : !l;
    fclk <= (s == 2'h1) ? l : !l;
    ta <= (s == 2'h2) ? l : !l;
    tb <= (s == 2'h3) ? l : !l;
  endtask
  task automatic t_regs();
    wr(PG_OFS_FIRST, 16'h8005);
    rd(PG_OFS_FIRST, 16'h0005);
    wr(PG_OFS_FIRST, 16'h0000);
    wr(PG_OFS_LAST, 16'h0001);
    rd(PG_OFS_LAST, 16'h0001);
    rd(PG_OFS_RSVD, 16'h0000);
    wr(PG_OFS_TBLO, 16'h0001);
    rd(PG_OFS_TBLO, 16'h0001);
    wr(8'h1e, 16'hffff);
    rd(8'h1e, 16'h0000);
  endtask
  task automatic t_mem();
    wr(PG_OFS_HPTR, 16'h0000);
    wr(PG_OFS_HPORT, 16'h1111);
    wr(PG_OFS_HPORT, 16'ha0a0);
    wr(PG_OFS_HPORT, 16'h2222);
    wr(PG_OFS_HPORT, 16'hb0b0);
    rd(PG_OFS_HPTR, 16'h0004);
    wr(PG_OFS_HPTR, 16'h0001);
    wr(PG_OFS_OUTSET, 16'hc000);
    rd(PG_OFS_HPORT, 16'ha0a0);
    rd(PG_OFS_HPTR, 16'h0001);
    wr(PG_OFS_OUTSET, 16'h8000);
    rd(PG_OFS_HPORT, 16'ha0a0);
    rd(PG_OFS_HPTR, 16'h0002);
  endtask
  task automatic t_single();
    wr(PG_OFS_REPEAT, 16'h0002);
    wr(PG_OFS_IRQ, 16'h905a);
    stall <= 1'b1;
    q.delete();
    wr(PG_OFS_CTRL, 16'h0003);
    words(4);
    cyc(60);
    chk(16'(q.size()), 16'h0004);
    for (int i = 0; i < 4; i++)
    begin
      chk(q[i].data, i[0] ? 16'h2222 : 16'h1111);
      chk(q[i].oe, i[0] ? 16'hb0b0 : 16'ha0a0);
      chk(16'(q[i].marker), 16'h0001);
    end
    rd(PG_OFS_IRQ, 16'h915a);
    chk(16'(irq_n), 16'h0000);
    q.delete();
    wr(PG_OFS_CTRL, 16'h0043);
    words(4);
    cyc(60);
    chk(16'(q.size()), 16'h0004);
    wr(PG_OFS_CTRL, 16'h0000);
    stall <= 1'b0;
  endtask
  task automatic t_iack();
    logic [15:0] x;
    host.access(1'b0, 1'b1, 8'h00, 16'h0000, x);
    chk(x, 16'h005a);
    rd(PG_OFS_IRQ, 16'h915a);
    wr(PG_OFS_IRQ, 16'hd05a);
    host.access(1'b0, 1'b1, 8'h00, 16'h0000, x);
    cyc(3);
    rd(PG_OFS_IRQ, 16'h515a);
    chk(16'(irq_n), 16'h0001);
    wr(PG_OFS_IRQ, 16'h4100);
    rd(PG_OFS_IRQ, 16'h4000);
  endtask
  task automatic t_cont();
    wr(PG_OFS_PATCH_HI, 16'hc0c0);
    wr(PG_OFS_PATCH_LO, 16'h3333);
    wr(PG_OFS_PATCH_LOC, 16'h0000);
    wr(PG_OFS_CTRL, 16'h0011);
    wr(PG_OFS_MATCH, 16'h0001);
    wr(PG_OFS_FIRST, 16'h0001);
    hold <= 1'b1;
    cyc(30);
    q.delete();
    hold <= 1'b0;
    words(8);
    for (int i = 3; i < 8; i++)
    begin
      chk(16'(q[i].marker), 16'(q[i].data == 16'h2222));
      chk(q[i].data ^ q[i - 1].data, 16'h3333);
    end
    wr(PG_OFS_PATCH_LOC, 16'h0000);
    q.delete();
    words(7);
    for (int i = 3; i < 7; i++)
      chk(q[i].oe ^ q[i - 1].oe, 16'h7070);
    rd(PG_OFS_IRQ, 16'h4200);
    // full buffer, so no wrap event meets the reset
    hold <= 1'b1;
    cyc(20);
    wr(PG_OFS_CTRL, 16'h0080);
    rd(PG_OFS_IRQ, 16'h4000);
    chk(16'(run), 16'h0000);
    hold <= 1'b0;
    rd(PG_OFS_FIRST, 16'h0000);
    rd(PG_OFS_MATCH, 16'h0001);
  endtask
  task automatic t_go();
    logic [2:0] c;
    for (int i = 2; i < 8; i++)
    begin
      c = 3'(i);
      lines(c[2:1], !c[0]);
      wr(PG_OFS_CTRL, {1'b0, c, 12'h001});
      cyc(6);
      chk(16'(run), 16'h0000);
      lines(c[2:1], c[0]);
      cyc(6);
      chk(16'(run), 16'h0001);
      wr(PG_OFS_CTRL, 16'h0000);
    end
  endtask
  task automatic t_tb();
    logic [2:0] c;
    for (int i = 2; i < 8; i++)
    begin
      c = 3'(i);
      lines(c[2:1], 1'b0);
      wr(PG_OFS_CTRL, {5'h00, c, 8'h01});
      cyc(12);
      q.delete();
      lines(c[2:1], 1'b1);
      cyc(12);
      chk(16'(q.size()), 16'(!c[0]));
      lines(c[2:1], 1'b0);
      cyc(12);
      chk(16'(q.size()), 16'h0001);
      wr(PG_OFS_CTRL, 16'h0000);
    end
  endtask
  initial
  begin
    rst_n = 1'b0;
    {fclk, fgo, ta, tb, rdy, hold, stall} = 7'h00;
    fails = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_mem();
    t_single();
    t_iack();
    t_cont();
    t_go();
    t_tb();
    end_of_test();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule

// *** rtl/pg_pkg.sv ***
package pg_pkg;

  localparam logic [7:0] PG_OFS_CTRL = 8'h00;
  localparam logic [7:0] PG_OFS_IRQ = 8'h02;
  localparam logic [7:0] PG_OFS_RSVD = 8'h04;
  localparam logic [7:0] PG_OFS_FIRST = 8'h06;
  localparam logic [7:0] PG_OFS_LAST = 8'h08;
  localparam logic [7:0] PG_OFS_MATCH = 8'h0a;
  localparam logic [7:0] PG_OFS_OUTSET = 8'h0c;
  localparam logic [7:0] PG_OFS_TBHI = 8'h0e;
  localparam logic [7:0] PG_OFS_TBLO = 8'h10;
  localparam logic [7:0] PG_OFS_PATCH_LOC = 8'h12;
  localparam logic [7:0] PG_OFS_PATCH_HI = 8'h14;
  localparam logic [7:0] PG_OFS_PATCH_LO = 8'h16;
  localparam logic [7:0] PG_OFS_HPTR = 8'h18;
  localparam logic [7:0] PG_OFS_HPORT = 8'h1a;
  localparam logic [7:0] PG_OFS_REPEAT = 8'h1c;

  // control register fields
  localparam int PG_CTL_RUN = 0;
  localparam int PG_CTL_SINGLE = 1;
  localparam int PG_CTL_MODE = 2;
  localparam int PG_CTL_HIZ8 = 3;
  localparam int PG_CTL_SYNC = 4;
  localparam int PG_CTL_STEP = 6;
  localparam int PG_CTL_RST = 7;
  localparam int PG_CTL_TB_LSB = 8;
  localparam int PG_CTL_GO_LSB = 12;
  // irq register fields
  localparam int PG_IRQ_ONE_PEND = 8;
  localparam int PG_IRQ_LOOP_PEND = 9;
  localparam int PG_IRQ_ONE_EN = 12;
  localparam int PG_IRQ_LOOP_EN = 13;
  localparam int PG_IRQ_KIND = 14;
  localparam int PG_IRQ_MASTER = 15;
  // output setup fields
  localparam int PG_OUT_HOLD = 14;
  localparam int PG_OUT_HIZ_BITS = 15;

  localparam logic [2:0] PG_SRC_INTERNAL = 3'h0;
  localparam logic [2:0] PG_SRC_FRONT_LO = 3'h2;
  localparam logic [2:0] PG_SRC_FRONT_HI = 3'h3;
  localparam logic [2:0] PG_SRC_TRGA_LO = 3'h4;
  localparam logic [2:0] PG_SRC_TRGA_HI = 3'h5;
  localparam logic [2:0] PG_SRC_TRGB_LO = 3'h6;
  localparam logic [2:0] PG_SRC_TRGB_HI = 3'h7;

  localparam int PG_CLK_PERIOD_NS = 20;
  localparam int PG_TB_UNIT_NS = 50;
  localparam logic [6:0] PG_ACC_STEP = 7'(PG_CLK_PERIOD_NS);
  localparam logic [6:0] PG_ACC_UNIT = 7'(PG_TB_UNIT_NS);
  localparam int PG_MEM_WORDS = 32768;
  localparam logic [15:0] PG_RESET_VAL = 16'h0000;

  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_WAIT = 2'b01,
    PG_FETCH = 2'b10,
    PG_PUSH = 2'b11
  } pg_seq_state_t;

  typedef struct packed {
    logic marker;
    logic [15:0] oe;
    logic [15:0] data;
  } pg_word_t;

endpackage

// *** rtl/pg_regs.sv ***
`timescale 1ns/10ps
module pg_regs
  import pg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic bus_sel_in,
  input wire logic bus_wr_in,
  input wire logic bus_iack_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  output logic [15:0] bus_rdata_out,
  output logic bus_ack_out,
  output logic irq_n_out,
  input wire logic front_clock_in,
  input wire logic front_go_in,
  input wire logic trig_a_in,
  input wire logic trig_b_in,
  input wire logic pat_ready_in,
  output logic pat_valid_out,
  output logic [15:0] chan_data_out,
  output logic [15:0] chan_oe_out,
  output logic sync_mark_out,
  output logic running_out
);

  logic [15:0] ctrl_ff;
  logic [15:0] irqc_ff;
  logic [14:0] first_ff;
  logic [14:0] last_ff;
  logic [14:0] match_ff;
  logic [15:0] outset_ff;
  logic [15:0] tbhi_ff;
  logic [15:0] tblo_ff;
  logic [14:0] patch_loc_ff;
  logic [15:0] patch_hi_ff;
  logic [15:0] patch_lo_ff;
  logic [15:0] hptr_ff;
  logic [15:0] repeat_ff;
  logic [15:0] mem_hi [0:PG_MEM_WORDS-1];
  logic [15:0] mem_lo [0:PG_MEM_WORDS-1];
  logic [15:0] rdata_ff;
  logic ack_ff;
  logic irq_n_ff;
  logic step_ff;
  logic rst_ff;
  logic ev_loop_ff;
  logic ev_one_ff;

  logic wr;
  logic rd;
  logic idle;
  logic host_port_hit;
  logic patch_hit;
  assign wr = bus_sel_in & bus_wr_in & ~bus_iack_in;
  assign rd = bus_sel_in & ~bus_wr_in & ~bus_iack_in;
  assign idle = ~ctrl_ff[PG_CTL_RUN];
  assign host_port_hit = bus_sel_in & ~bus_iack_in & (bus_addr_in == PG_OFS_HPORT);
  assign patch_hit = wr & (bus_addr_in == PG_OFS_PATCH_LOC) & ~idle;

  // control register, step and reset pulses
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_ff <= PG_RESET_VAL;
      step_ff <= 1'b0;
      rst_ff <= 1'b0;
    end
    else
    begin
      step_ff <= 1'b0;
      rst_ff <= 1'b0;
      if (wr && bus_addr_in == PG_OFS_CTRL)
      begin
        ctrl_ff <= bus_wdata_in & 16'h771f;
        step_ff <= bus_wdata_in[PG_CTL_STEP];
        rst_ff <= bus_wdata_in[PG_CTL_RST];
        if (bus_wdata_in[PG_CTL_RST])
        begin
          ctrl_ff[PG_CTL_RUN] <= 1'b0;
        end
      end
    end
  end

  // interrupt control, pending flags, acknowledge
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irqc_ff <= PG_RESET_VAL;
    end
    else
    begin
      if (wr && bus_addr_in == PG_OFS_IRQ)
      begin
        irqc_ff[15:12] <= bus_wdata_in[15:12];
        irqc_ff[7:0] <= bus_wdata_in[7:0];
        if (bus_wdata_in[PG_IRQ_ONE_PEND])
        begin
          irqc_ff[PG_IRQ_ONE_PEND] <= 1'b0;
        end
        if (bus_wdata_in[PG_IRQ_LOOP_PEND])
        begin
          irqc_ff[PG_IRQ_LOOP_PEND] <= 1'b0;
        end
      end
      if (rst_ff)
      begin
        irqc_ff[PG_IRQ_ONE_PEND] <= 1'b0;
        irqc_ff[PG_IRQ_LOOP_PEND] <= 1'b0;
      end
      if (bus_sel_in && bus_iack_in && irqc_ff[PG_IRQ_KIND])
      begin
        irqc_ff[PG_IRQ_MASTER] <= 1'b0;
      end
      if (ev_one_ff)
      begin
        irqc_ff[PG_IRQ_ONE_PEND] <= 1'b1;
      end
      if (ev_loop_ff)
      begin
        irqc_ff[PG_IRQ_LOOP_PEND] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_n_ff <= 1'b1;
    end
    else
    begin
      irq_n_ff <= ~(irqc_ff[PG_IRQ_MASTER] &
        ((irqc_ff[PG_IRQ_LOOP_EN] & irqc_ff[PG_IRQ_LOOP_PEND]) |
         (irqc_ff[PG_IRQ_ONE_EN] & irqc_ff[PG_IRQ_ONE_PEND])));
    end
  end

  // setup registers with write permission classes
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      first_ff <= 15'h0000;
      last_ff <= 15'h0000;
      match_ff <= 15'h0000;
      outset_ff <= PG_RESET_VAL;
      tbhi_ff <= PG_RESET_VAL;
      tblo_ff <= PG_RESET_VAL;
      patch_loc_ff <= 15'h0000;
      patch_hi_ff <= PG_RESET_VAL;
      patch_lo_ff <= PG_RESET_VAL;
      repeat_ff <= PG_RESET_VAL;
    end
    else if (wr)
    begin
      if (bus_addr_in == PG_OFS_FIRST && idle)
      begin
        first_ff <= bus_wdata_in[14:0];
      end
      else if (bus_addr_in == PG_OFS_LAST && idle)
      begin
        last_ff <= bus_wdata_in[14:0];
      end
      else if (bus_addr_in == PG_OFS_MATCH)
      begin
        match_ff <= bus_wdata_in[14:0];
      end
      else if (bus_addr_in == PG_OFS_OUTSET && idle)
      begin
        outset_ff <= bus_wdata_in;
      end
      else if (bus_addr_in == PG_OFS_TBHI)
      begin
        tbhi_ff <= bus_wdata_in;
      end
      else if (bus_addr_in == PG_OFS_TBLO)
      begin
        tblo_ff <= bus_wdata_in;
      end
      else if (bus_addr_in == PG_OFS_PATCH_LOC && !idle)
      begin
        patch_loc_ff <= bus_wdata_in[14:0];
      end
      else if (bus_addr_in == PG_OFS_PATCH_HI)
      begin
        patch_hi_ff <= bus_wdata_in;
      end
      else if (bus_addr_in == PG_OFS_PATCH_LO)
      begin
        patch_lo_ff <= bus_wdata_in;
      end
      else if (bus_addr_in == PG_OFS_REPEAT)
      begin
        repeat_ff <= bus_wdata_in;
      end
    end
  end

  // host memory pointer
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hptr_ff <= PG_RESET_VAL;
    end
    else if (wr && bus_addr_in == PG_OFS_HPTR)
    begin
      hptr_ff <= bus_wdata_in;
    end
    else if (host_port_hit && (idle || !bus_wr_in) && !outset_ff[PG_OUT_HOLD])
    begin
      hptr_ff <= hptr_ff + 16'h0001;
    end
  end

  // pattern memory writes: host port halves and live patch
  always_ff @(posedge core_clk_in)
  begin
    if (patch_hit)
    begin
      mem_hi[bus_wdata_in[14:0]] <= patch_hi_ff;
      mem_lo[bus_wdata_in[14:0]] <= patch_lo_ff;
    end
    else if (host_port_hit && bus_wr_in && idle)
    begin
      if (hptr_ff[0])
      begin
        mem_hi[hptr_ff[15:1]] <= bus_wdata_in;
      end
      else
      begin
        mem_lo[hptr_ff[15:1]] <= bus_wdata_in;
      end
    end
  end

  // bus read answer and acknowledge vector
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_ff <= PG_RESET_VAL;
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= bus_sel_in;
      if (bus_sel_in && bus_iack_in)
      begin
        rdata_ff <= {8'h00, irqc_ff[7:0]};
      end
      else if (rd)
      begin
        if (bus_addr_in == PG_OFS_CTRL)
        begin
          rdata_ff <= ctrl_ff;
        end
        else if (bus_addr_in == PG_OFS_IRQ)
        begin
          rdata_ff <= {irqc_ff[15:12], 2'b00, irqc_ff[9:0]};
        end
        else if (bus_addr_in == PG_OFS_FIRST)
        begin
          rdata_ff <= {1'b0, first_ff};
        end
        else if (bus_addr_in == PG_OFS_LAST)
        begin
          rdata_ff <= {1'b0, last_ff};
        end
        else if (bus_addr_in == PG_OFS_MATCH)
        begin
          rdata_ff <= {1'b0, match_ff};
        end
        else if (bus_addr_in == PG_OFS_OUTSET)
        begin
          rdata_ff <= outset_ff;
        end
        else if (bus_addr_in == PG_OFS_TBHI)
        begin
          rdata_ff <= tbhi_ff;
        end
        else if (bus_addr_in == PG_OFS_TBLO)
        begin
          rdata_ff <= tblo_ff;
        end
        else if (bus_addr_in == PG_OFS_PATCH_LOC)
        begin
          rdata_ff <= {1'b0, patch_loc_ff};
        end
        else if (bus_addr_in == PG_OFS_PATCH_HI)
        begin
          rdata_ff <= patch_hi_ff;
        end
        else if (bus_addr_in == PG_OFS_PATCH_LO)
        begin
          rdata_ff <= patch_lo_ff;
        end
        else if (bus_addr_in == PG_OFS_HPTR)
        begin
          rdata_ff <= hptr_ff;
        end
        else if (bus_addr_in == PG_OFS_HPORT)
        begin
          rdata_ff <= hptr_ff[0] ? mem_hi[hptr_ff[15:1]] : mem_lo[hptr_ff[15:1]];
        end
        else if (bus_addr_in == PG_OFS_REPEAT)
        begin
          rdata_ff <= repeat_ff;
        end
        else
        begin
          rdata_ff <= 16'h0000;
        end
      end
    end
  end

  // timebase: 50 ns units from 20 ns clock via accumulator
  logic [6:0] acc_ff;
  logic [31:0] unit_cnt_ff;
  logic int_tick_ff;
  logic front_q_ff;
  logic trga_q_ff;
  logic trgb_q_ff;
  logic tick;
  logic go_level;
  logic active;
  logic [2:0] tb_sel;
  logic [2:0] go_sel;
  assign tb_sel = ctrl_ff[PG_CTL_TB_LSB +: 3];
  assign go_sel = ctrl_ff[PG_CTL_GO_LSB +: 3];

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      acc_ff <= 7'h00;
      unit_cnt_ff <= 32'h00000000;
      int_tick_ff <= 1'b0;
    end
    else
    begin
      int_tick_ff <= 1'b0;
      if (acc_ff + PG_ACC_STEP >= PG_ACC_UNIT)
      begin
        acc_ff <= acc_ff + PG_ACC_STEP - PG_ACC_UNIT;
        if (unit_cnt_ff >= {tbhi_ff, tblo_ff})
        begin
          unit_cnt_ff <= 32'h00000000;
          int_tick_ff <= 1'b1;
        end
        else
        begin
          unit_cnt_ff <= unit_cnt_ff + 32'h00000001;
        end
      end
      else
      begin
        acc_ff <= acc_ff + PG_ACC_STEP;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      front_q_ff <= 1'b0;
      trga_q_ff <= 1'b0;
      trgb_q_ff <= 1'b0;
    end
    else
    begin
      front_q_ff <= front_clock_in;
      trga_q_ff <= trig_a_in;
      trgb_q_ff <= trig_b_in;
    end
  end

  always_comb
  begin
    tick = 1'b0;
    if (tb_sel == PG_SRC_INTERNAL)
    begin
      tick = int_tick_ff;
    end
    else if (tb_sel == PG_SRC_FRONT_LO)
    begin
      tick = front_clock_in & ~front_q_ff;
    end
    else if (tb_sel == PG_SRC_FRONT_HI)
    begin
      tick = ~front_clock_in & front_q_ff;
    end
    else if (tb_sel == PG_SRC_TRGA_LO)
    begin
      tick = trig_a_in & ~trga_q_ff;
    end
    else if (tb_sel == PG_SRC_TRGA_HI)
    begin
      tick = ~trig_a_in & trga_q_ff;
    end
    else if (tb_sel == PG_SRC_TRGB_LO)
    begin
      tick = trig_b_in & ~trgb_q_ff;
    end
    else if (tb_sel == PG_SRC_TRGB_HI)
    begin
      tick = ~trig_b_in & trgb_q_ff;
    end
  end

  always_comb
  begin
    go_level = 1'b0;
    if (go_sel == PG_SRC_INTERNAL)
    begin
      go_level = 1'b1;
    end
    else if (go_sel == PG_SRC_FRONT_LO)
    begin
      go_level = ~front_go_in;
    end
    else if (go_sel == PG_SRC_FRONT_HI)
    begin
      go_level = front_go_in;
    end
    else if (go_sel == PG_SRC_TRGA_LO)
    begin
      go_level = ~trig_a_in;
    end
    else if (go_sel == PG_SRC_TRGA_HI)
    begin
      go_level = trig_a_in;
    end
    else if (go_sel == PG_SRC_TRGB_LO)
    begin
      go_level = ~trig_b_in;
    end
    else if (go_sel == PG_SRC_TRGB_HI)
    begin
      go_level = trig_b_in;
    end
  end
  assign active = ctrl_ff[PG_CTL_RUN] & go_level;

  // sequencer
  pg_seq_state_t state_ff;
  logic [14:0] ptr_ff;
  logic [15:0] loops_ff;
  logic done_ff;
  logic tick_pend_ff;
  logic [15:0] fetch_hi_ff;
  logic [15:0] fetch_lo_ff;
  logic [14:0] fetch_ptr_ff;
  logic push;
  logic in_ready;
  pg_word_t word_in;

  always_comb
  begin
    word_in.marker = ctrl_ff[PG_CTL_SYNC] ? (fetch_ptr_ff == match_ff) : 1'b1;
    word_in.data = fetch_lo_ff;
    word_in.oe = 16'hffff;
    if (ctrl_ff[PG_CTL_MODE])
    begin
      if (ctrl_ff[PG_CTL_HIZ8])
      begin
        word_in.data = {8'h00, fetch_lo_ff[7:0]};
        word_in.oe = {8'h00, fetch_lo_ff[15:8]};
      end
    end
    else if (outset_ff[PG_OUT_HIZ_BITS])
    begin
      word_in.oe = fetch_hi_ff;
    end
  end
  assign push = (state_ff == PG_PUSH) & in_ready;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_pend_ff <= 1'b0;
    end
    else if (tick)
    begin
      tick_pend_ff <= 1'b1;
    end
    else if (state_ff == PG_WAIT || state_ff == PG_IDLE)
    begin
      tick_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= PG_IDLE;
      ptr_ff <= 15'h0000;
      loops_ff <= PG_RESET_VAL;
      done_ff <= 1'b0;
      fetch_hi_ff <= PG_RESET_VAL;
      fetch_lo_ff <= PG_RESET_VAL;
      fetch_ptr_ff <= 15'h0000;
      ev_loop_ff <= 1'b0;
      ev_one_ff <= 1'b0;
    end
    else
    begin
      ev_loop_ff <= 1'b0;
      ev_one_ff <= 1'b0;
      if (step_ff || !ctrl_ff[PG_CTL_RUN])
      begin
        done_ff <= 1'b0;
      end
      if (rst_ff || !active)
      begin
        state_ff <= PG_IDLE;
      end
      else
      begin
        case (state_ff)
          PG_IDLE:
          begin
            if (!done_ff || step_ff)
            begin
              ptr_ff <= first_ff;
              loops_ff <= repeat_ff;
              state_ff <= PG_WAIT;
            end
          end
          PG_WAIT:
          begin
            if (tick_pend_ff)
            begin
              state_ff <= PG_FETCH;
            end
          end
          PG_FETCH:
          begin
            fetch_hi_ff <= mem_hi[ptr_ff];
            fetch_lo_ff <= mem_lo[ptr_ff];
            fetch_ptr_ff <= ptr_ff;
            state_ff <= PG_PUSH;
          end
          PG_PUSH:
          begin
            if (in_ready)
            begin
              state_ff <= PG_WAIT;
              ptr_ff <= ptr_ff + 15'h0001;
              if (fetch_ptr_ff == last_ff)
              begin
                ptr_ff <= first_ff;
                if (!ctrl_ff[PG_CTL_SINGLE])
                begin
                  ev_loop_ff <= 1'b1;
                end
                else if (loops_ff <= 16'h0001)
                begin
                  ev_one_ff <= 1'b1;
                  done_ff <= 1'b1;
                  state_ff <= PG_IDLE;
                end
                else
                begin
                  loops_ff <= loops_ff - 16'h0001;
                end
              end
            end
          end
          default:
          begin
            state_ff <= PG_IDLE;
          end
        endcase
      end
    end
  end

  // two-entry output buffer, head drives the channels
  pg_word_t head_ff;
  pg_word_t second_ff;
  logic [1:0] cnt_ff;
  logic pop;
  assign in_ready = (cnt_ff != 2'd2);
  assign pop = (cnt_ff != 2'd0) & pat_ready_in;

  // marker of the next head word
  logic nxt_mark;
  always_comb
  begin
    nxt_mark = head_ff.marker;
    if (cnt_ff == 2'd2)
    begin
      if (pop)
      begin
        nxt_mark = second_ff.marker;
      end
    end
    else if (push && (cnt_ff == 2'd0 || pop))
    begin
      nxt_mark = word_in.marker;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      head_ff <= '0;
      second_ff <= '0;
      cnt_ff <= 2'd0;
    end
    else
    begin
      if (cnt_ff == 2'd2)
      begin
        if (pop)
        begin
          head_ff <= second_ff;
        end
      end
      else if (push && (cnt_ff == 2'd0 || pop))
      begin
        head_ff <= word_in;
      end
      else if (push)
      begin
        second_ff <= word_in;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pat_valid_out <= 1'b0;
      sync_mark_out <= 1'b0;
      running_out <= 1'b0;
    end
    else
    begin
      pat_valid_out <= (cnt_ff + {1'b0, push} - {1'b0, pop}) != 2'd0;
      sync_mark_out <= nxt_mark & ((cnt_ff + {1'b0, push} - {1'b0, pop}) != 2'd0);
      running_out <= (state_ff != PG_IDLE);
    end
  end

  assign chan_data_out = head_ff.data;
  assign chan_oe_out = head_ff.oe;
  assign bus_rdata_out = rdata_ff;
  assign bus_ack_out = ack_ff;
  assign irq_n_out = irq_n_ff;

endmodule
